/* include/pmi_regs.svh */
`ifndef PMI_REGS_SVH
`define PMI_REGS_SVH

// Configuration offsets on the link
`define PMI_CAP_OFS      8'h46
`define PMI_CSR_OFS      8'h48
// Control/status field positions
`define PMI_CSR_WSTS     15
`define PMI_CSR_WEN      8
`define PMI_CSR_ST_HI    1
`define PMI_CSR_ST_LO    0
// Power state codes
`define PMI_ST_D0        2'h0
`define PMI_ST_D1        2'h1
`define PMI_ST_D3HOT     2'h3
// Capability word fixed parts
`define PMI_CAP_HI_VAL   6'h19
`define PMI_CAP_VER_VAL  3'h1
// Internal function reset length after leaving D3hot
`define PMI_FRST_CYCLES  3'h4
// Controller register byte addresses
`define PMI_HR_CTRL      8'h00
`define PMI_HR_WDATA     8'h04
`define PMI_HR_STAT      8'h08
`define PMI_HR_RDATA     8'h0C
`define PMI_HR_ISR       8'h10
`define PMI_HR_IMR       8'h14
// Controller field positions
`define PMI_CTRL_WE      8
`define PMI_CTRL_GO      9
`define PMI_EV_DONE      0
`define PMI_EV_WAKE      1
`define PMI_EV_REFUSED   2
`endif

/* include/pmi_pkg.sv */
package pmi_pkg;
  // Controller access sequencer
  typedef enum logic [1:0] {
    PMI_IDLE = 2'b00,
    PMI_REQ  = 2'b01,
    PMI_GAP  = 2'b10
  } pmi_fsm_t;

  // Device end state
  typedef struct packed {
    logic        ack;
    logic [15:0] rdata;
    logic        wake_status;
    logic        wake_enable;
    logic [1:0]  power_state;
    logic        wake_out;
    logic [2:0]  frst_cnt;
    logic        frst;
  } pmi_dev_state_t;

  // Controller end state
  typedef struct packed {
    pmi_fsm_t    fsm;
    logic [7:0]  ofs;
    logic        we;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic        refused;
    logic [2:0]  isr;
    logic [2:0]  imr;
    logic        wake_q;
    logic        wb_ack;
    logic [31:0] wb_dat;
    logic        irq;
    logic        req;
  } pmi_host_state_t;
endpackage

/* include/pmi_link_if.sv */
interface pmi_link_if;
  logic        req;
  logic        we;
  logic [7:0]  addr;
  logic [15:0] wdata;
  logic        ack;
  logic [15:0] rdata;
  logic        wake;

  modport dev (
    input  req,
    input  we,
    input  addr,
    input  wdata,
    output ack,
    output rdata,
    output wake
  );

  modport host (
    output req,
    output we,
    output addr,
    output wdata,
    input  ack,
    input  rdata,
    input  wake
  );
endinterface

/* hw/pmi_device.sv */
`include "pmi_regs.svh"

module pmi_device (
  input  wire logic        CLOCK,
  input  wire logic        RESETN,
  pmi_link_if.dev          LINK,
  input  wire logic        WAKE_EVENT,
  output logic [1:0]       POWER_STATE,
  output logic             FUNC_RESET,
  output logic             WAKE_ACTIVE
);

  pmi_pkg::pmi_dev_state_t st;
  pmi_pkg::pmi_dev_state_t next_st;

  // Capability low bits are constants; upper bits are fixed straps here
  function automatic logic [15:0] cap_word();
    logic [15:0] w;
    w        = 16'h0000;
    w[15:10] = `PMI_CAP_HI_VAL;
    w[9]     = 1'b0;
    w[8]     = 1'b0;
    w[7:6]   = 2'b00;
    w[5]     = 1'b0;
    w[4]     = 1'b0;
    w[3]     = 1'b0;
    w[2:0]   = `PMI_CAP_VER_VAL;
    return w;
  endfunction

  // Control/status read image; every unlisted bit stays zero
  function automatic logic [15:0] csr_word(
    input logic       sts,
    input logic       en,
    input logic [1:0] pst
  );
    logic [15:0] w;
    w = 16'h0000;
    w[`PMI_CSR_WSTS] = sts;
    w[`PMI_CSR_WEN]  = en;
    w[`PMI_CSR_ST_HI:`PMI_CSR_ST_LO] = pst;
    return w;
  endfunction

  logic        csr_wr;
  logic        take;
  logic [1:0]  wr_state;
  logic        leave_d3;

  // Next-state logic
  always_comb begin
    next_st  = st;
    take     = LINK.req && !st.ack;
    csr_wr   = take && LINK.we && (LINK.addr == `PMI_CSR_OFS);
    wr_state = LINK.wdata[`PMI_CSR_ST_HI:`PMI_CSR_ST_LO];
    leave_d3 = 1'b0;

    // One ack per request; the controller holds req until it sees it
    next_st.ack = take;

    // Reads sample the image before this cycle's write lands
    if (take && !LINK.we) begin
      if (LINK.addr == `PMI_CAP_OFS) begin
        next_st.rdata = cap_word();
      end else if (LINK.addr == `PMI_CSR_OFS) begin
        next_st.rdata = csr_word(st.wake_status, st.wake_enable, st.power_state);
      end else begin
        next_st.rdata = 16'h0000;
      end
    end

    if (csr_wr) begin
      // Kept writable: wake support is advertised, so no hardwired zero
      next_st.wake_enable = LINK.wdata[`PMI_CSR_WEN];
      // Unsupported D1 code is dropped, old state stays
      if (wr_state != `PMI_ST_D1) begin
        next_st.power_state = wr_state;
        leave_d3 = (st.power_state == `PMI_ST_D3HOT) && (wr_state == `PMI_ST_D0);
      end
    end

    // Write-one-to-clear; a new event in the same cycle wins
    if (csr_wr && LINK.wdata[`PMI_CSR_WSTS]) begin
      next_st.wake_status = 1'b0;
    end
    if (WAKE_EVENT) begin
      next_st.wake_status = 1'b1;
    end

    // Wake line follows status gated by enable, so a clear drops it
    next_st.wake_out = next_st.wake_status && next_st.wake_enable;

    // Internal function reset leaves this register alone
    if (leave_d3) begin
      next_st.frst_cnt = `PMI_FRST_CYCLES;
      next_st.frst     = 1'b1;
    end else if (st.frst_cnt != 3'h0) begin
      next_st.frst_cnt = st.frst_cnt - 3'h1;
      next_st.frst     = (st.frst_cnt != 3'h1);
    end else begin
      next_st.frst     = 1'b0;
    end
  end

  // Only the external reset touches control/status
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      st.ack         <= 1'b0;
      st.rdata       <= 16'h0000;
      st.wake_status <= 1'b0;
      st.wake_enable <= 1'b0;
      st.power_state <= `PMI_ST_D0;
      st.wake_out    <= 1'b0;
      st.frst_cnt    <= 3'h0;
      st.frst        <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from flip-flops
  assign LINK.ack    = st.ack;
  assign LINK.rdata  = st.rdata;
  assign LINK.wake   = st.wake_out;
  assign POWER_STATE = st.power_state;
  assign FUNC_RESET  = st.frst;
  assign WAKE_ACTIVE = st.wake_out;

endmodule

/* hw/pmi_host.sv */
`include "pmi_regs.svh"

module pmi_host (
  input  wire logic        CLOCK,
  input  wire logic        RESETN,
  pmi_link_if.host         LINK,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic [31:0]      WB_DAT_O,
  output logic             WB_ACK_O,
  output logic             IRQ
);

  pmi_pkg::pmi_host_state_t st;
  pmi_pkg::pmi_host_state_t next_st;

  // Byte-lane merge for a 16-bit field
  function automatic logic [15:0] lane16(
    input logic [15:0] old,
    input logic [31:0] d,
    input logic [3:0]  sel
  );
    logic [15:0] w;
    w = old;
    if (sel[0]) begin
      w[7:0] = d[7:0];
    end
    if (sel[1]) begin
      w[15:8] = d[15:8];
    end
    return w;
  endfunction

  logic        wb_hit;
  logic        wb_wr;
  logic        go;
  logic        bad_state;
  logic [2:0]  ev;
  logic [15:0] ctrl_new;

  always_comb begin
    next_st   = st;
    wb_hit    = WB_CYC_I && WB_STB_I && !st.wb_ack;
    wb_wr     = wb_hit && WB_WE_I;
    ev        = 3'h0;
    go        = 1'b0;
    bad_state = 1'b0;
    ctrl_new  = lane16({7'h00, st.we, st.ofs}, WB_DAT_I, WB_SEL_I);

    // Classic Wishbone: ack one cycle after the strobe, dropped next cycle
    next_st.wb_ack = wb_hit;
    if (wb_hit && !WB_WE_I) begin
      if (WB_ADR_I == `PMI_HR_CTRL) begin
        next_st.wb_dat = {22'h00_0000, 1'b0, st.we, st.ofs};
      end else if (WB_ADR_I == `PMI_HR_WDATA) begin
        next_st.wb_dat = {16'h0000, st.wdata};
      end else if (WB_ADR_I == `PMI_HR_STAT) begin
        next_st.wb_dat = {29'h0000_0000, st.refused, st.wake_q, st.fsm != pmi_pkg::PMI_IDLE};
      end else if (WB_ADR_I == `PMI_HR_RDATA) begin
        next_st.wb_dat = {16'h0000, st.rdata};
      end else if (WB_ADR_I == `PMI_HR_ISR) begin
        next_st.wb_dat = {29'h0000_0000, st.isr};
      end else if (WB_ADR_I == `PMI_HR_IMR) begin
        next_st.wb_dat = {29'h0000_0000, st.imr};
      end else begin
        next_st.wb_dat = 32'h0000_0000;
      end
    end

    // Register writes; go is ignored while an access is in flight
    if (wb_wr) begin
      if (WB_ADR_I == `PMI_HR_CTRL) begin
        if (st.fsm == pmi_pkg::PMI_IDLE) begin
          next_st.ofs = ctrl_new[7:0];
          next_st.we  = ctrl_new[`PMI_CTRL_WE];
          go          = WB_SEL_I[1] && WB_DAT_I[`PMI_CTRL_GO];
        end
      end else if (WB_ADR_I == `PMI_HR_WDATA) begin
        if (st.fsm == pmi_pkg::PMI_IDLE) begin
          next_st.wdata = lane16(st.wdata, WB_DAT_I, WB_SEL_I);
        end
      end else if (WB_ADR_I == `PMI_HR_ISR) begin
        if (WB_SEL_I[0]) begin
          next_st.isr = st.isr & ~WB_DAT_I[2:0];
        end
      end else if (WB_ADR_I == `PMI_HR_IMR) begin
        if (WB_SEL_I[0]) begin
          next_st.imr = WB_DAT_I[2:0];
        end
      end
    end

    // Never ask the device for D1
    bad_state = next_st.we && (next_st.ofs == `PMI_CSR_OFS) &&
                (next_st.wdata[`PMI_CSR_ST_HI:`PMI_CSR_ST_LO] == `PMI_ST_D1);

    // Link sequencer: hold request until ack, then one idle cycle
    case (st.fsm)
      pmi_pkg::PMI_IDLE: begin
        if (go && bad_state) begin
          next_st.refused = 1'b1;
          ev[`PMI_EV_REFUSED] = 1'b1;
        end else if (go) begin
          next_st.refused = 1'b0;
          next_st.req     = 1'b1;
          next_st.fsm     = pmi_pkg::PMI_REQ;
        end
      end
      pmi_pkg::PMI_REQ: begin
        if (LINK.ack) begin
          next_st.req = 1'b0;
          if (!st.we) begin
            next_st.rdata = LINK.rdata;
          end
          ev[`PMI_EV_DONE] = 1'b1;
          next_st.fsm      = pmi_pkg::PMI_GAP;
        end
      end
      pmi_pkg::PMI_GAP: begin
        next_st.fsm = pmi_pkg::PMI_IDLE;
      end
      default: begin
        next_st.fsm = pmi_pkg::PMI_IDLE;
        next_st.req = 1'b0;
      end
    endcase

    // Rising wake line is an event; software clears it with a W1C
    // status write that it issues through CTRL/WDATA
    next_st.wake_q = LINK.wake;
    ev[`PMI_EV_WAKE] = LINK.wake && !st.wake_q;

    // Set wins over a clear in the same cycle
    next_st.isr = next_st.isr | ev;
    next_st.irq = |(next_st.isr & next_st.imr);
  end

  // Enable of wake starts cleared on the device; nothing to restore here
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      st.fsm     <= pmi_pkg::PMI_IDLE;
      st.ofs     <= 8'h00;
      st.we      <= 1'b0;
      st.wdata   <= 16'h0000;
      st.rdata   <= 16'h0000;
      st.refused <= 1'b0;
      st.isr     <= 3'h0;
      st.imr     <= 3'h0;
      st.wake_q  <= 1'b0;
      st.wb_ack  <= 1'b0;
      st.wb_dat  <= 32'h0000_0000;
      st.irq     <= 1'b0;
      st.req     <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign LINK.req   = st.req;
  assign LINK.we    = st.we;
  assign LINK.addr  = st.ofs;
  assign LINK.wdata = st.wdata;
  assign WB_DAT_O   = st.wb_dat;
  assign WB_ACK_O   = st.wb_ack;
  assign IRQ        = st.irq;

endmodule

/* testbench/ppmr_checker.sv */
module ppmr_checker (
  input wire logic        CLOCK,
  input wire logic        RESETN,
  input wire logic        req,
  input wire logic        we,
  input wire logic [7:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        ack,
  input wire logic [15:0] rdata,
  input wire logic        wake
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RESETN);

  // Completed link accesses, seen in the ack cycle
  logic rd_cap;
  logic rd_csr;
  logic wr_csr;
  assign rd_cap = ack && !we && addr == 8'h46;
  assign rd_csr = ack && !we && addr == 8'h48;
  assign wr_csr = ack && we && addr == 8'h48;

  a_ack_follows: // link timing
    assert property (req && !ack |=> ack) else $error("link ack missing");
  a_ack_single: // link timing
    assert property (ack |=> !ack && !req) else $error("ack or req lingers");
  a_cap_fixed:
    assert property (rd_cap |-> rdata[9:0] == 10'h001) else $error("cap low bits");
  a_csr_zeros:
    assert property (rd_csr |-> rdata[14:9] == 6'h00 && rdata[7:2] == 6'h00)
      else $error("csr read-only bits");
  a_wake_level:
    assert property (rd_csr |-> $past(wake) == (rdata[15] & rdata[8])) else $error("wake level");
  a_clear_drops:
    assert property (wr_csr && wdata[15] |=> !wake) else $error("wake kept after clear");
  a_enable_gates:
    assert property (wr_csr && !wdata[8] |=> !wake) else $error("wake while disabled");
  a_wake_falls:
    assert property ($fell(wake) |-> (ack && we) || $past(ack && we))
      else $error("wake fell without write");
  a_no_state1:
    assert property (req && we && addr == 8'h48 |-> wdata[1:0] != 2'h1)
      else $error("state 01 requested");
endmodule

/* testbench/pci_power_mgmt_regs_tb_top.sv */
module pci_power_mgmt_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock;
  logic        resetn;
  logic        cyc;
  logic        stb;
  logic        wwe;
  logic        evt;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat;
  logic [31:0] dat_o;
  logic        ack_o;
  logic        irq;
  logic        frst;
  logic        wact;
  logic [1:0]  pst;
  logic [15:0] q;
  logic [2:0]  s;
  logic [31:0] t;
  int          n_fail;
  int          compares;
  int          fr_n;
  int          fr0;

  pmi_link_if pmi_link_if_i ();
  pmi_device pmi_device_i (.CLOCK(clock), .RESETN(resetn), .LINK(pmi_link_if_i), .WAKE_EVENT(evt),
    .POWER_STATE(pst), .FUNC_RESET(frst), .WAKE_ACTIVE(wact));
  pmi_host pmi_host_i (.CLOCK(clock), .RESETN(resetn), .LINK(pmi_link_if_i), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(wwe), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat),
    .WB_DAT_O(dat_o), .WB_ACK_O(ack_o), .IRQ(irq));
  ppmr_checker ppmr_checker_i (.CLOCK(clock), .RESETN(resetn), .req(pmi_link_if_i.req),
    .we(pmi_link_if_i.we), .addr(pmi_link_if_i.addr), .wdata(pmi_link_if_i.wdata),
    .ack(pmi_link_if_i.ack), .rdata(pmi_link_if_i.rdata), .wake(pmi_link_if_i.wake));

  // Clock source
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Running total of cycles with the internal reset high, summed over all pulses
  always @(posedge clock) begin
    if (frst === 1'b1) fr_n <= fr_n + 1;
  end

  task automatic end_of_test;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One classic cycle; waits on ack, bench timeout cuts a hang
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    wwe <= w;
    adr <= a;
    dat <= d;
    do @(posedge clock); while (ack_o !== 1'b1);
    r = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // Link access through the controller; polls done or refused
  task automatic lop(input logic w, input logic [15:0] d, input logic [7:0] a,
                     output logic [15:0] r, output logic [2:0] st);
    logic [31:0] x;
    int n;
    wb(1'b1, 8'h04, {16'h0000, d}, x);
    wb(1'b1, 8'h00, {22'h00_0000, 1'b1, w, a}, x);
    n = 0;
    do begin
      wb(1'b0, 8'h10, 32'h0000_0000, x);
      n++;
    end while (x[0] !== 1'b1 && x[2] !== 1'b1 && n < 20);
    // Poll limit spent without an answer counts as a mismatch
    if (x[0] !== 1'b1 && x[2] !== 1'b1) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, x, 32'h0000_0001);
    end
    st = x[2:0];
    wb(1'b1, 8'h10, 32'h0000_0005, x);
    wb(1'b0, 8'h0C, 32'h0000_0000, x);
    r = x[15:0];
  endtask

  // Single-cycle wake event, then time to settle
  task automatic pulse;
    @(posedge clock);
    evt <= 1'b1;
    @(posedge clock);
    evt <= 1'b0;
    repeat (3) @(posedge clock);
  endtask

  // Watchdog sized well past the whole sequence
  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    end_of_test;
  end

  initial begin
    {resetn, cyc, stb, wwe, evt, adr, dat, n_fail, compares} = '0;
    sel = 4'hF;
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    lop(1'b0, 16'h0000, 8'h46, q, s);
    chk(q, 16'h6401);
    lop(1'b0, 16'h0000, 8'h48, q, s);
    chk(q, 16'h0000);
    lop(1'b1, 16'hFFFE, 8'h48, q, s);
    lop(1'b0, 16'h0000, 8'h48, q, s);
    chk(q, 16'h0102);
    chk(pst, 2'h2);
    lop(1'b1, 16'h0103, 8'h48, q, s);
    lop(1'b1, 16'h0101, 8'h48, q, s);
    chk(s[2], 1'b1);
    wb(1'b0, 8'h08, 32'h0000_0000, t);
    chk(t, 32'h0000_0004);
    lop(1'b0, 16'h0000, 8'h48, q, s);
    chk(q, 16'h0103);
    fr0 = fr_n;
    lop(1'b1, 16'h0100, 8'h48, q, s);
    lop(1'b0, 16'h0000, 8'h48, q, s);
    chk(q, 16'h0100);
    chk(fr_n - fr0, 4);
    // Enabled wake raises the link line and the unmasked interrupt
    wb(1'b1, 8'h14, 32'h0000_0002, t);
    wb(1'b0, 8'h14, 32'h0000_0000, t);
    chk(t, 32'h0000_0002);
    pulse;
    chk(pmi_link_if_i.wake, 1'b1);
    chk(irq, 1'b1);
    lop(1'b1, 16'h8100, 8'h48, q, s);
    chk(pmi_link_if_i.wake, 1'b0);
    wb(1'b1, 8'h10, 32'h0000_0002, t);
    chk(irq, 1'b0);
    // Disabled wake still records status
    lop(1'b1, 16'h0000, 8'h48, q, s);
    wb(1'b1, 8'h14, 32'h0000_0000, t);
    pulse;
    chk(pmi_link_if_i.wake, 1'b0);
    lop(1'b1, 16'h0000, 8'h48, q, s);
    lop(1'b0, 16'h0000, 8'h48, q, s);
    chk(q, 16'h8000);
    // Late enable raises wake; masked until the mask opens
    lop(1'b1, 16'h0100, 8'h48, q, s);
    chk(wact, 1'b1);
    wb(1'b0, 8'h08, 32'h0000_0000, t);
    chk(t, 32'h0000_0002);
    chk(irq, 1'b0);
    wb(1'b1, 8'h14, 32'h0000_0002, t);
    chk(irq, 1'b1);
    wb(1'b1, 8'h10, 32'h0000_0002, t);
    lop(1'b1, 16'h8100, 8'h48, q, s);
    lop(1'b0, 16'h0000, 8'h48, q, s);
    chk(q, 16'h0100);
    wb(1'b0, 8'h20, 32'h0000_0000, t);
    chk(t, 32'h0000_0000);
    // Command and data registers read back the last read command
    wb(1'b0, 8'h00, 32'h0000_0000, t);
    chk(t, 32'h0000_0048);
    wb(1'b0, 8'h04, 32'h0000_0000, t);
    chk(t, 32'h0000_0000);
    end_of_test;
  end
endmodule
